// ### hw/iep_pkg.sv
package iep_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] PRIO_OFFSET   = 8'hb8;
   localparam logic [7:0] ENABLE_OFFSET = 8'he8;
   localparam logic [7:0] STATUS_OFFSET = 8'hec;

   // ----------------------------------------------------------------
   // priority register fields
   // ----------------------------------------------------------------
   localparam int PRIO_EXT0_BIT = 0;
   localparam int PRIO_TMR0_BIT = 1;
   localparam int PRIO_EXT1_BIT = 2;
   localparam int PRIO_TMR1_BIT = 3;
   localparam int PRIO_WIDTH    = 4;
   localparam logic [3:0] PRIO_RESET = 4'h0;

   // ----------------------------------------------------------------
   // extended enable register fields
   // ----------------------------------------------------------------
   localparam int EN_CIPHER_BIT = 2;
   localparam int EN_TMR3_BIT   = 3;
   localparam int EN_SLEEP_BIT  = 4;
   localparam int EN_SPI_BIT    = 5;
   localparam int EN_VOICE_BIT  = 6;
   localparam logic [7:0] ENABLE_RESET = 8'h00;

   // ----------------------------------------------------------------
   // status register fields
   // ----------------------------------------------------------------
   localparam int ST_LO_SVC_BIT = 0;
   localparam int ST_HI_SVC_BIT = 1;
   localparam int ST_REQ_BIT    = 2;
   localparam int ST_HI_REQ_BIT = 3;
   localparam int ST_VEC_LSB    = 4;

   // ----------------------------------------------------------------
   // source indices, lowest index wins within a level
   // ----------------------------------------------------------------
   localparam int NUM_SRC   = 9;
   localparam int SRC_EXT0  = 0;
   localparam int SRC_TMR0  = 1;
   localparam int SRC_EXT1  = 2;
   localparam int SRC_TMR1  = 3;
   localparam int SRC_CIPH  = 4;
   localparam int SRC_TMR3  = 5;
   localparam int SRC_SLEEP = 6;
   localparam int SRC_SPI   = 7;
   localparam int SRC_VOICE = 8;
   localparam int VEC_W     = 4;
endpackage

// ### hw/iep_pick.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// fixed polling order picker, one result per priority level
// ----------------------------------------------------------------
module iep_pick #(
   parameter int N = iep_pkg::NUM_SRC,
   parameter int W = iep_pkg::VEC_W
) (
   input  wire logic [N-1:0] req,
   input  wire logic [N-1:0] hi_mask,
   output logic              found_hi,
   output logic [W-1:0]      idx_hi,
   output logic              found_lo,
   output logic [W-1:0]      idx_lo
);
   initial begin
      if (N < 1 || N > (1 << W)) begin
         $error("iep_pick: source count does not fit the index width");
      end
   end

   // lowest set bit wins; shared by both levels
   function automatic logic [W:0] first_set(input logic [N-1:0] v);
      logic [W:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, W'(i)};
         end
      end
      return r;
   endfunction

   always_comb begin
      {found_hi, idx_hi} = first_set(req & hi_mask);
      {found_lo, idx_lo} = first_set(req & ~hi_mask);
   end
endmodule
`default_nettype wire

// ### hw/iep_irq_enable_priority_regs.sv
// Contract
// - timer one priority bit 3 set makes its interrupt high priority.
// - external line one priority bit 2 set makes it high priority.
// - timer zero priority bit 1 set makes its interrupt high priority.
// - external line zero bit 0 set raises it; priority bits RW, reset 0.
// - enable bit 0 blocks its source request, 1 passes it; RW, reset 0.
// - enable bits: 6 voice, 5 serial, 4 sleep, 3 timer three, 2 cipher.
`timescale 1ns/1ns
`default_nettype none
module iep_irq_enable_priority_regs #(
   parameter int NSRC = iep_pkg::NUM_SRC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_line_zero_req,
   input  wire logic        timer_zero_req,
   input  wire logic        ext_line_one_req,
   input  wire logic        timer_one_req,
   input  wire logic        cipher_engine_req,
   input  wire logic        third_timer_req,
   input  wire logic        sleep_timer_req,
   input  wire logic        serial_periph_req,
   input  wire logic        voice_path_req,
   input  wire logic        core_irq_ack,
   input  wire logic        core_irq_return,
   output logic             irq_req,
   output logic             irq_high,
   output logic [3:0]       irq_vector
);
   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   initial begin
      if (NSRC != iep_pkg::NUM_SRC) begin
         $error("iep: source map is fixed at nine sources");
      end
   end

   // ----------------------------------------------------------------
   // registers and next values
   // ----------------------------------------------------------------
   logic [3:0]  prio_q,    prio_d;
   logic [7:0]  enable_q,  enable_d;
   logic [31:0] prdata_q,  prdata_d;
   logic        pready_q,  pready_d;
   logic        pslverr_q, pslverr_d;
   logic        lo_svc_q,  lo_svc_d;
   logic        hi_svc_q,  hi_svc_d;
   logic        req_q,     req_d;
   logic        high_q,    high_d;
   logic [3:0]  vec_q,     vec_d;

   logic [NSRC-1:0] src_req;
   logic [NSRC-1:0] src_hi;
   logic            found_hi;
   logic            found_lo;
   logic [3:0]      idx_hi;
   logic [3:0]      idx_lo;
   logic            setup;
   logic            access;
   logic            mapped;
   logic [31:0]     rd_word;

   // ----------------------------------------------------------------
   // request gating and level assignment
   // ----------------------------------------------------------------
   always_comb begin
      src_req = '0;
      src_hi  = '0;
      // the four classic sources have no gate in this block
      src_req[iep_pkg::SRC_EXT0]  = ext_line_zero_req;
      src_req[iep_pkg::SRC_TMR0]  = timer_zero_req;
      src_req[iep_pkg::SRC_EXT1]  = ext_line_one_req;
      src_req[iep_pkg::SRC_TMR1]  = timer_one_req;
      src_req[iep_pkg::SRC_CIPH]  = cipher_engine_req
                                  & enable_q[iep_pkg::EN_CIPHER_BIT];
      src_req[iep_pkg::SRC_TMR3]  = third_timer_req
                                  & enable_q[iep_pkg::EN_TMR3_BIT];
      src_req[iep_pkg::SRC_SLEEP] = sleep_timer_req
                                  & enable_q[iep_pkg::EN_SLEEP_BIT];
      src_req[iep_pkg::SRC_SPI]   = serial_periph_req
                                  & enable_q[iep_pkg::EN_SPI_BIT];
      src_req[iep_pkg::SRC_VOICE] = voice_path_req
                                  & enable_q[iep_pkg::EN_VOICE_BIT];
      src_hi[iep_pkg::SRC_TMR1]   = prio_q[iep_pkg::PRIO_TMR1_BIT];
      src_hi[iep_pkg::SRC_EXT1]   = prio_q[iep_pkg::PRIO_EXT1_BIT];
      src_hi[iep_pkg::SRC_TMR0]   = prio_q[iep_pkg::PRIO_TMR0_BIT];
      src_hi[iep_pkg::SRC_EXT0]   = prio_q[iep_pkg::PRIO_EXT0_BIT];
      // the extended sources' level bits lie elsewhere: they stay low here
   end

   iep_pick #(
      .N (NSRC),
      .W (iep_pkg::VEC_W)
   ) u_pick (
      .req      (src_req),
      .hi_mask  (src_hi),
      .found_hi (found_hi),
      .idx_hi   (idx_hi),
      .found_lo (found_lo),
      .idx_lo   (idx_lo)
   );

   // ----------------------------------------------------------------
   // apb decode and read mux
   // ----------------------------------------------------------------
   always_comb begin
      setup   = psel & ~penable;
      access  = psel & penable & pready_q;
      mapped  = (paddr == iep_pkg::PRIO_OFFSET)
              | (paddr == iep_pkg::ENABLE_OFFSET)
              | (paddr == iep_pkg::STATUS_OFFSET);
      rd_word = '0;
      case (paddr)
         iep_pkg::PRIO_OFFSET: begin
            rd_word[iep_pkg::PRIO_WIDTH-1:0] = prio_q;
         end
         iep_pkg::ENABLE_OFFSET: begin
            rd_word[7:0] = enable_q;
         end
         iep_pkg::STATUS_OFFSET: begin
            rd_word[iep_pkg::ST_LO_SVC_BIT] = lo_svc_q;
            rd_word[iep_pkg::ST_HI_SVC_BIT] = hi_svc_q;
            rd_word[iep_pkg::ST_REQ_BIT]    = req_q;
            rd_word[iep_pkg::ST_HI_REQ_BIT] = high_q;
            rd_word[iep_pkg::ST_VEC_LSB +: iep_pkg::VEC_W] = vec_q;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // register file next state
   // ----------------------------------------------------------------
   always_comb begin
      prio_d    = prio_q;
      enable_d  = enable_q;
      prdata_d  = prdata_q;
      pslverr_d = 1'b0;
      // answer fixed at one access cycle: pready rises with the setup edge
      pready_d  = setup;
      if (setup) begin
         prdata_d  = pwrite ? '0 : rd_word;
         pslverr_d = ~mapped;
      end else if (access) begin
         pslverr_d = pslverr_q;
         if (pwrite && paddr == iep_pkg::PRIO_OFFSET) begin
            prio_d = pwdata[iep_pkg::PRIO_WIDTH-1:0];
         end
         if (pwrite && paddr == iep_pkg::ENABLE_OFFSET) begin
            // the reserved bits 0, 1 and 7 are kept as plain storage
            enable_d = pwdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // service levels and request presentation
   // ----------------------------------------------------------------
   always_comb begin
      lo_svc_d = lo_svc_q;
      hi_svc_d = hi_svc_q;
      // an acknowledge claims the level of the request shown that cycle
      if (core_irq_ack && req_q) begin
         if (high_q) begin
            hi_svc_d = 1'b1;
         end else begin
            lo_svc_d = 1'b1;
         end
      end else if (core_irq_return) begin
         // a return ends the innermost, i.e. highest, routine; it is ignored in a cycle that takes an acknowledge
         if (hi_svc_q) begin
            hi_svc_d = 1'b0;
         end else begin
            lo_svc_d = 1'b0;
         end
      end
      req_d  = 1'b0;
      high_d = 1'b0;
      vec_d  = vec_q;
      // hide the request in the ack cycle so it is not taken twice
      if (core_irq_ack && req_q) begin
         req_d = 1'b0;
      end else if (found_hi && !hi_svc_d) begin
         req_d  = 1'b1;
         high_d = 1'b1;
         vec_d  = idx_hi;
      end else if (found_lo && !hi_svc_d && !lo_svc_d) begin
         req_d  = 1'b1;
         vec_d  = idx_lo;
      end
   end

   // ----------------------------------------------------------------
   // flip-flops
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio_q    <= iep_pkg::PRIO_RESET;
         enable_q  <= iep_pkg::ENABLE_RESET;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         lo_svc_q  <= 1'b0;
         hi_svc_q  <= 1'b0;
         req_q     <= 1'b0;
         high_q    <= 1'b0;
         vec_q     <= 4'h0;
      end else begin
         prio_q    <= prio_d;
         enable_q  <= enable_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         lo_svc_q  <= lo_svc_d;
         hi_svc_q  <= hi_svc_d;
         req_q     <= req_d;
         high_q    <= high_d;
         vec_q     <= vec_d;
      end
   end

   always_comb begin
      prdata     = prdata_q;
      pready     = pready_q;
      pslverr    = pslverr_q;
      irq_req    = req_q;
      irq_high   = high_q;
      irq_vector = vec_q;
   end
endmodule
`default_nettype wire

// ### tb/iep_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module iep_chk #(
   parameter int NSRC = iep_pkg::NUM_SRC
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        ext_line_zero_req,
   input wire logic        timer_zero_req,
   input wire logic        ext_line_one_req,
   input wire logic        timer_one_req,
   input wire logic        cipher_engine_req,
   input wire logic        third_timer_req,
   input wire logic        sleep_timer_req,
   input wire logic        serial_periph_req,
   input wire logic        voice_path_req,
   input wire logic        core_irq_ack,
   input wire logic        core_irq_return,
   input wire logic        irq_req,
   input wire logic        irq_high,
   input wire logic [3:0]  irq_vector
);
   logic [3:0]      prio_q, prio_d;
   logic [7:0]      en_q, en_d;
   logic            hi_q, hi_d;
   logic            wr;
   logic [NSRC-1:0] eff, eff_q;
   // ----------------------------------------------------------------
   // shadow of written bits, gated requests and high service state
   // ----------------------------------------------------------------
   assign wr  = psel && penable && pready && pwrite;
   assign eff = {voice_path_req & en_q[6], serial_periph_req & en_q[5],
      sleep_timer_req & en_q[4], third_timer_req & en_q[3], cipher_engine_req & en_q[2],
      timer_one_req, ext_line_one_req, timer_zero_req, ext_line_zero_req};
   always_comb begin
      prio_d = (wr && paddr == iep_pkg::PRIO_OFFSET) ? pwdata[3:0] : prio_q;
      en_d   = (wr && paddr == iep_pkg::ENABLE_OFFSET) ? pwdata[7:0] : en_q;
      hi_d   = (core_irq_ack && irq_req && irq_high) ? 1'b1 : (core_irq_return ? 1'b0 : hi_q);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio_q <= '0;
         en_q   <= '0;
         hi_q   <= 1'b0;
         eff_q  <= '0;
      end else begin
         prio_q <= prio_d;
         en_q   <= en_d;
         hi_q   <= hi_d;
         eff_q  <= eff;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_tmr1_hi; irq_req && irq_vector == 4'h3 |-> irq_high == $past(prio_q[3]); endproperty
   a_tmr1_hi: assert property (p_tmr1_hi) else $error("timer one level wrong");
   property p_ext1_hi; irq_req && irq_vector == 4'h2 |-> irq_high == $past(prio_q[2]); endproperty
   a_ext1_hi: assert property (p_ext1_hi) else $error("line one level wrong");
   property p_tmr0_hi; irq_req && irq_vector == 4'h1 |-> irq_high == $past(prio_q[1]); endproperty
   a_tmr0_hi: assert property (p_tmr0_hi) else $error("timer zero level wrong");
   property p_ext0_hi; irq_req && irq_vector == 4'h0 |-> irq_high == $past(prio_q[0]); endproperty
   a_ext0_hi: assert property (p_ext0_hi) else $error("line zero level wrong");
   property p_gate; eff == '0 |=> !irq_req; endproperty
   a_gate: assert property (p_gate) else $error("blocked request shown");
   property p_map; irq_req |-> eff_q[irq_vector]; endproperty
   a_map: assert property (p_map) else $error("vector names no live source");
   property p_pre; (|(eff[3:0] & prio_q)) && !hi_q && !(core_irq_ack && irq_req)
      |=> irq_req && irq_high; endproperty
   a_pre: assert property (p_pre) else $error("high request not shown");
   c_high: cover property (irq_req && irq_high);
   c_take: cover property (core_irq_ack && irq_req);
   c_voice: cover property (irq_req && irq_vector == 4'h8);
endmodule
bind iep_irq_enable_priority_regs iep_chk #(.NSRC(NSRC)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .ext_line_zero_req(ext_line_zero_req),
   .timer_zero_req(timer_zero_req), .ext_line_one_req(ext_line_one_req),
   .timer_one_req(timer_one_req), .cipher_engine_req(cipher_engine_req),
   .third_timer_req(third_timer_req), .sleep_timer_req(sleep_timer_req),
   .serial_periph_req(serial_periph_req), .voice_path_req(voice_path_req),
   .core_irq_ack(core_irq_ack), .core_irq_return(core_irq_return), .irq_req(irq_req),
   .irq_high(irq_high), .irq_vector(irq_vector));
`default_nettype wire

// ### tb/iep_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// core side: one take strobe per presented request, only while allowed
module iep_core_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ack_en,
   input  wire logic irq_req,
   output logic      core_irq_ack
);
   logic ack_d;
   always_comb begin
      ack_d = ack_en && irq_req && !core_irq_ack;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_irq_ack <= 1'b0;
      end else begin
         core_irq_ack <= ack_d;
      end
   end
endmodule
`default_nettype wire

// ### tb/test_irq_enable_priority_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_irq_enable_priority_regs;
   logic        pclk, presetn, psel, penable, pwrite, ack_en, ret, ack, err;
   logic        pready, pslverr, irq_req, irq_high;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  irq_vector;
   logic [8:0]  src;
   int          n_mismatch, cmp_count;
   iep_irq_enable_priority_regs u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_line_zero_req(src[0]), .timer_zero_req(src[1]), .ext_line_one_req(src[2]),
      .timer_one_req(src[3]), .cipher_engine_req(src[4]), .third_timer_req(src[5]),
      .sleep_timer_req(src[6]), .serial_periph_req(src[7]), .voice_path_req(src[8]),
      .core_irq_ack(ack), .core_irq_return(ret), .irq_req(irq_req), .irq_high(irq_high),
      .irq_vector(irq_vector));
   iep_core_model u_core (.pclk(pclk), .presetn(presetn), .ack_en(ack_en),
      .irq_req(irq_req), .core_irq_ack(ack));
   always #5 pclk = ~pclk;
   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_mismatch++;
         finish_test;
      end
   endtask
   // requests move one edge after their cause, so two edges settle them
   task automatic wt;
      repeat (2) @(posedge pclk);
      #1;
   endtask
   task automatic t_regs;
      apb(0, iep_pkg::PRIO_OFFSET, 0); chk("prio reset", 0, rd);
      apb(0, iep_pkg::ENABLE_OFFSET, 0); chk("enable reset", 0, rd);
      apb(1, iep_pkg::PRIO_OFFSET, 32'hffffffff);
      apb(1, 8'h10, 32'h0); chk("unmapped wr err", 1, err);
      apb(0, iep_pkg::PRIO_OFFSET, 0); chk("prio rw", 32'hf, rd);
      chk("mapped no err", 0, err);
      apb(1, iep_pkg::ENABLE_OFFSET, 32'hfc);
      apb(0, iep_pkg::ENABLE_OFFSET, 0); chk("enable rw", 32'hfc, rd);
      apb(0, 8'h10, 0); chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
      apb(1, iep_pkg::PRIO_OFFSET, 0);
      apb(1, iep_pkg::ENABLE_OFFSET, 0);
   endtask
   task automatic t_gate;
      for (int i = 0; i < 5; i++) begin
         @(posedge pclk);
         src <= 9'h010 << i;
         wt; chk("blocked", 0, irq_req);
         apb(1, iep_pkg::ENABLE_OFFSET, 32'h4 << i);
         wt; chk("passed", 1, irq_req);
         chk("ext vector", 4 + i, irq_vector);
         @(posedge pclk);
         src <= '0;
         apb(1, iep_pkg::ENABLE_OFFSET, 0);
      end
   endtask
   task automatic t_prio;
      for (int j = 0; j < 4; j++) begin
         apb(1, iep_pkg::PRIO_OFFSET, 32'h1 << j);
         @(posedge pclk);
         src <= 9'h001 << j;
         wt; chk("raised", 1, irq_high);
         chk("vector", j, irq_vector);
         apb(1, iep_pkg::PRIO_OFFSET, 32'hf ^ (32'h1 << j));
         wt; chk("left low", 0, irq_high);
         @(posedge pclk);
         src <= '0;
      end
      apb(1, iep_pkg::PRIO_OFFSET, 0);
   endtask
   task automatic t_preempt;
      apb(1, iep_pkg::PRIO_OFFSET, 32'h8);
      @(posedge pclk);
      src <= 9'h003;
      wt; chk("poll order", 0, irq_vector);
      @(posedge pclk);
      ack_en <= 1'b1;
      repeat (3) @(posedge pclk);
      ack_en <= 1'b0;
      wt; chk("low hidden", 0, irq_req);
      @(posedge pclk);
      src <= 9'h00b;
      wt; chk("preempt req", 1, irq_req);
      chk("preempt vec", 3, irq_vector);
      chk("preempt high", 1, irq_high);
      @(posedge pclk);
      ack_en <= 1'b1;
      repeat (3) @(posedge pclk);
      ack_en <= 1'b0;
      wt; chk("high hidden", 0, irq_req);
      apb(0, iep_pkg::STATUS_OFFSET, 0); chk("both in service", 32'h3, rd[3:0]);
      @(posedge pclk);
      ret <= 1'b1;
      @(posedge pclk);
      ret <= 1'b0;
      wt; chk("high again", 1, irq_req & irq_high);
      @(posedge pclk);
      src <= 9'h003;
      wt; chk("low still held", 0, irq_req);
      @(posedge pclk);
      src <= '0;
      ret <= 1'b1;
      @(posedge pclk);
      ret <= 1'b0;
      apb(1, iep_pkg::PRIO_OFFSET, 0);
      apb(0, iep_pkg::STATUS_OFFSET, 0); chk("service left", 32'h0, rd[3:0]);
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      {pclk, presetn, psel, penable, pwrite, ack_en, ret} = '0;
      {paddr, pwdata, src, n_mismatch, cmp_count} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_gate;
      t_prio;
      t_preempt;
      finish_test;
   end
endmodule
`default_nettype wire
